// ==== hw/rscc_pkg.sv ====
package rscc_pkg;

  localparam int unsigned CLK_PERIOD_PS    = 4000;
  localparam int unsigned HEARTBEAT_MS     = 500;
  localparam int unsigned HEARTBEAT_CYCLES =
    (HEARTBEAT_MS * 1000 * 1000) / (CLK_PERIOD_PS / 1000);
  localparam int unsigned INIT_CYCLES      = 16;

  localparam logic [15:0] CMD_ENTER_CAL    = 16'h2329;
  localparam logic [15:0] CMD_UNIT_WEIGHT  = 16'h232A;
  localparam logic [15:0] CMD_MEASURING_PHASE_WEIGHT  = 16'h232B;
  localparam logic [15:0] CMD_WEIGHT_MASS  = 16'h232C;

  localparam logic [15:0] ERR_NONE         = 16'h0000;
  localparam logic [15:0] ERR_CODE_CAL     = 16'h0063;
  localparam logic [15:0] AUX_NONE         = 16'h0000;
  localparam logic [15:0] AUX_OUT_OF_RANGE = 16'h0001;
  localparam logic [15:0] AUX_UNEXECUTABLE = 16'h0002;

  localparam logic [31:0] WEIGHT_MIN       = 32'h0000_0001;
  localparam logic [31:0] WEIGHT_MAX       = 32'h000F_423F;

  localparam logic [2:0]  CAL_STEP_NONE    = 3'h0;
  localparam logic [2:0]  CAL_STEP_MODE    = 3'h1;
  localparam logic [2:0]  CAL_STEP_UNIT    = 3'h2;
  localparam logic [2:0]  CAL_STEP_MEASURING_PHASE    = 3'h3;
  localparam logic [2:0]  CAL_STEP_MASS    = 3'h4;

  typedef enum logic [1:0]
  {
    RSCC_IDLE = 2'b00,
    RSCC_EXEC = 2'b01,
    RSCC_DONE = 2'b11
  } rscc_cmd_state_t;

endpackage

// ==== hw/rscc_link_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface rscc_link_if;
  logic        write_req;
  logic        write_resp;
  logic        gen_req;
  logic        gen_resp;
  logic        rw_dir;
  logic        mode_req;
  logic        mode_resp;
  logic        cpu_alive;
  logic [2:0]  dp_code;
  logic [12:0] seq_status;
  logic        capacity_over;
  logic        faulty_weight;
  logic [15:0] cal_number_bcd;
  logic        init_done_flag;
  logic        error_status;
  logic        remote_ready;
  logic        four_station;
  logic [15:0] cmd_word;
  logic [31:0] arg_words;
  logic [15:0] err_code;
  logic [15:0] aux_err_code;

  modport device
  (
    input  write_req, gen_req, mode_req, init_done_flag, four_station, cmd_word, arg_words,
    output write_resp, gen_resp, rw_dir, mode_resp, cpu_alive, dp_code, seq_status,
    output capacity_over, faulty_weight, cal_number_bcd, error_status, remote_ready,
    output err_code, aux_err_code
  );
  modport master
  (
    output write_req, gen_req, mode_req, init_done_flag, four_station, cmd_word, arg_words,
    input  write_resp, gen_resp, rw_dir, mode_resp, cpu_alive, dp_code, seq_status,
    input  capacity_over, faulty_weight, cal_number_bcd, error_status, remote_ready,
    input  err_code, aux_err_code
  );
endinterface
`default_nettype wire

// ==== hw/rscc_device.sv ====
// Function
// R1: Write response after write, clears after request drops
// R2: Command response after issue, clears after release
// R3: Direction bit: high readout, low write
// R4: Mode-switching response unsupported, held low
// R5: Heartbeat toggles every half second
// R6: Decimal point as three-bit binary code
// R7: Sequence states mirrored onto status bits
// R8: Capacity-over while any overload or overflow
// R9: Faulty weight on excess or zero error
// R10: Calibration number driven as BCD
// R11: Initial-data flag ignored, no initialization
// R12: Error status high while indicator errs
// R13: Remote ready low until initialization done
// R14: Master calibrates only via shared general command
// R15: Command and argument words per sharing mode
// R16: Termination restores pre-calibration state
// R17: Master confirms stabilization before registering; rscc_master has no such check
// R18: 9001 needs zero argument, else 99/1
// R19: 9001 outside measurement or locked gives 99/2
// R20: 9002 accepts 1,2,5,10,20,50 only
// R21: 9003 range 1..999999, order checked
// R22: 9004 range 1..999999, not above measuring
// R23: Error codes settle before command response; rscc_device sets both in the same EXEC cycle
`timescale 1ns/1ps
`default_nettype none
module rscc_device #(
  parameter int unsigned HEARTBEAT_CYCLES = rscc_pkg::HEARTBEAT_CYCLES,
  parameter int unsigned INIT_CYCLES      = rscc_pkg::INIT_CYCLES
)(
  input  wire logic        sys_clk,
  input  wire logic        rst,
  rscc_link_if.device      link,
  input  wire logic        write_done,
  input  wire logic        store_busy,
  input  wire logic [2:0]  dp_position,
  input  wire logic [12:0] seq_state,
  input  wire logic        overload_positive,
  input  wire logic        overflow_positive,
  input  wire logic        overload_negative,
  input  wire logic        overflow_negative,
  input  wire logic        weight_excess,
  input  wire logic        zero_set_error,
  input  wire logic [15:0] cal_number_bcd,
  input  wire logic        indicator_error,
  input  wire logic        measurement_display,
  input  wire logic        cal_lock,
  input  wire logic        cal_terminate,
  output logic             cal_mode,
  output logic [2:0]       cal_step,
  output logic [7:0]       unit_weight,
  output logic [31:0]      measuring_phase_weight,
  output logic [31:0]      weight_mass
);

  logic [2:0]  wreq_sync_r;
  logic [2:0]  greq_sync_r;
  logic        wreq_r;
  logic        greq_r;
  logic        write_resp_r;
  logic        gen_resp_r;
  logic        rw_dir_r;
  logic        cpu_alive_r;
  logic [31:0] hb_cnt_r;
  logic [31:0] init_cnt_r;
  logic        ready_r;
  logic [15:0] err_r;
  logic [15:0] aux_r;
  logic [15:0] cmd_r;
  logic [31:0] arg_r;
  logic        cal_mode_r;
  logic [2:0]  cal_step_r;
  logic [7:0]  unit_r;
  logic [31:0] measuring_phase_r;
  logic [31:0] mass_r;
  logic [7:0]  unit_sv_r;
  logic [31:0] measuring_phase_sv_r;
  logic [31:0] mass_sv_r;
  logic [2:0]  dp_r;
  logic [12:0] seq_r;
  logic        cap_r;
  logic        fault_r;
  logic [15:0] bcd_r;
  logic        errst_r;
  rscc_pkg::rscc_cmd_state_t st_r;

  function automatic logic in_weight_range(input logic [31:0] v);
    in_weight_range = (v >= rscc_pkg::WEIGHT_MIN) && (v <= rscc_pkg::WEIGHT_MAX);
  endfunction

  // Request synchronisers, change counts when stages two and three agree
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      wreq_sync_r <= 3'h0;
      greq_sync_r <= 3'h0;
      wreq_r      <= 1'b0;
      greq_r      <= 1'b0;
    end
    else
    begin
      wreq_sync_r <= {wreq_sync_r[1:0], link.write_req};
      greq_sync_r <= {greq_sync_r[1:0], link.gen_req};
      if (wreq_sync_r[1] == wreq_sync_r[2])
        wreq_r <= wreq_sync_r[2];
      if (greq_sync_r[1] == greq_sync_r[2])
        greq_r <= greq_sync_r[2];
    end
  end

  // Write handshake
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      write_resp_r <= 1'b0;
    else if (wreq_r && write_done)
      write_resp_r <= 1'b1; // R1
    else if (!wreq_r)
      write_resp_r <= 1'b0; // R1
  end

  // Heartbeat, paused while storing
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      hb_cnt_r    <= 32'h0;
      cpu_alive_r <= 1'b0;
    end
    else if (!store_busy)
    begin
      if (hb_cnt_r >= 32'(HEARTBEAT_CYCLES - 1))
      begin
        hb_cnt_r    <= 32'h0;
        cpu_alive_r <= ~cpu_alive_r; // R5
      end
      else
        hb_cnt_r <= hb_cnt_r + 32'h1;
    end
  end

  // Initialization then remote ready
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      init_cnt_r <= 32'h0;
      ready_r    <= 1'b0;
    end
    else if (init_cnt_r >= 32'(INIT_CYCLES - 1))
      ready_r <= 1'b1; // R13
    else
      init_cnt_r <= init_cnt_r + 32'h1;
  end

  // Status mirrors, registered
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      dp_r    <= 3'h0;
      seq_r   <= 13'h0;
      cap_r   <= 1'b0;
      fault_r <= 1'b0;
      bcd_r   <= 16'h0;
      errst_r <= 1'b0;
    end
    else
    begin
      dp_r    <= dp_position; // R6
      seq_r   <= seq_state; // R7
      cap_r   <= overload_positive | overflow_positive
               | overload_negative | overflow_negative; // R8
      fault_r <= weight_excess | zero_set_error; // R9
      bcd_r   <= cal_number_bcd; // R10
      errst_r <= indicator_error; // R12
    end
  end

  // General command handshake
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      st_r       <= rscc_pkg::RSCC_IDLE;
      gen_resp_r <= 1'b0;
      rw_dir_r   <= 1'b0;
      cmd_r      <= 16'h0;
      arg_r      <= 32'h0;
    end
    else
    begin
      unique case (st_r)
        rscc_pkg::RSCC_IDLE:
        begin
          if (greq_r && ready_r)
          begin
            cmd_r <= link.cmd_word; // R15
            arg_r <= link.arg_words; // R15
            st_r  <= rscc_pkg::RSCC_EXEC;
          end
        end
        rscc_pkg::RSCC_EXEC:
        begin
          gen_resp_r <= 1'b1; // R23
          rw_dir_r   <= 1'b0; // R3
          st_r       <= rscc_pkg::RSCC_DONE;
        end
        rscc_pkg::RSCC_DONE:
        begin
          if (!greq_r)
          begin
            gen_resp_r <= 1'b0; // R2
            st_r       <= rscc_pkg::RSCC_IDLE;
          end
        end
      endcase
    end
  end

  // Calibration command interpreter, result set in EXEC
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      err_r      <= rscc_pkg::ERR_NONE;
      aux_r      <= rscc_pkg::AUX_NONE;
      cal_mode_r <= 1'b0;
      cal_step_r <= rscc_pkg::CAL_STEP_NONE;
      unit_r     <= 8'h0;
      measuring_phase_r     <= 32'h0;
      mass_r     <= 32'h0;
      unit_sv_r  <= 8'h0;
      measuring_phase_sv_r  <= 32'h0;
      mass_sv_r  <= 32'h0;
    end
    else if (cal_terminate && cal_mode_r)
    begin
      cal_mode_r <= 1'b0; // R16
      cal_step_r <= rscc_pkg::CAL_STEP_NONE; // R16
      unit_r     <= unit_sv_r; // R16
      measuring_phase_r     <= measuring_phase_sv_r; // R16
      mass_r     <= mass_sv_r; // R16
    end
    else if (st_r == rscc_pkg::RSCC_EXEC)
    begin
      err_r <= rscc_pkg::ERR_NONE;
      aux_r <= rscc_pkg::AUX_NONE;
      if (cmd_r == rscc_pkg::CMD_ENTER_CAL)
      begin
        if (arg_r != 32'h0)
        begin
          err_r <= rscc_pkg::ERR_CODE_CAL; // R18
          aux_r <= rscc_pkg::AUX_OUT_OF_RANGE;
        end
        else if (!measurement_display || cal_lock || cal_mode_r)
        begin
          err_r <= rscc_pkg::ERR_CODE_CAL; // R19
          aux_r <= rscc_pkg::AUX_UNEXECUTABLE;
        end
        else
        begin
          cal_mode_r <= 1'b1;
          cal_step_r <= rscc_pkg::CAL_STEP_MODE;
          unit_sv_r  <= unit_r; // R16
          measuring_phase_sv_r  <= measuring_phase_r; // R16
          mass_sv_r  <= mass_r; // R16
        end
      end
      else if (cmd_r == rscc_pkg::CMD_UNIT_WEIGHT)
      begin
        if (!cal_mode_r)
        begin
          err_r <= rscc_pkg::ERR_CODE_CAL; // R20
          aux_r <= rscc_pkg::AUX_UNEXECUTABLE;
        end
        else if (!(arg_r inside {32'h1, 32'h2, 32'h5, 32'hA, 32'h14, 32'h32}))
        begin
          err_r <= rscc_pkg::ERR_CODE_CAL; // R20
          aux_r <= rscc_pkg::AUX_OUT_OF_RANGE;
        end
        else
        begin
          unit_r     <= arg_r[7:0];
          cal_step_r <= rscc_pkg::CAL_STEP_UNIT;
        end
      end
      else if (cmd_r == rscc_pkg::CMD_MEASURING_PHASE_WEIGHT)
      begin
        if (!cal_mode_r || cal_step_r < rscc_pkg::CAL_STEP_UNIT)
        begin
          err_r <= rscc_pkg::ERR_CODE_CAL; // R21
          aux_r <= rscc_pkg::AUX_UNEXECUTABLE;
        end
        else if (!in_weight_range(arg_r))
        begin
          err_r <= rscc_pkg::ERR_CODE_CAL; // R21
          aux_r <= rscc_pkg::AUX_OUT_OF_RANGE;
        end
        else
        begin
          measuring_phase_r     <= arg_r;
          cal_step_r <= rscc_pkg::CAL_STEP_MEASURING_PHASE;
        end
      end
      else if (cmd_r == rscc_pkg::CMD_WEIGHT_MASS)
      begin
        if (!cal_mode_r || cal_step_r < rscc_pkg::CAL_STEP_MEASURING_PHASE)
        begin
          err_r <= rscc_pkg::ERR_CODE_CAL; // R22
          aux_r <= rscc_pkg::AUX_UNEXECUTABLE;
        end
        else if (!in_weight_range(arg_r) || arg_r > measuring_phase_r)
        begin
          err_r <= rscc_pkg::ERR_CODE_CAL; // R22
          aux_r <= rscc_pkg::AUX_OUT_OF_RANGE;
        end
        else
        begin
          mass_r     <= arg_r;
          cal_step_r <= rscc_pkg::CAL_STEP_MASS;
        end
      end
    end
  end

  assign link.write_resp     = write_resp_r;
  assign link.gen_resp       = gen_resp_r;
  assign link.rw_dir         = rw_dir_r;
  assign link.mode_resp      = 1'b0; // R4
  assign link.cpu_alive      = cpu_alive_r;
  assign link.dp_code        = dp_r;
  assign link.seq_status     = seq_r;
  assign link.capacity_over  = cap_r;
  assign link.faulty_weight  = fault_r;
  assign link.cal_number_bcd = bcd_r;
  assign link.error_status   = errst_r; // R11: init_done_flag is never read
  assign link.remote_ready   = ready_r;
  assign link.err_code       = err_r;
  assign link.aux_err_code   = aux_r;
  assign cal_mode            = cal_mode_r;
  assign cal_step            = cal_step_r;
  assign unit_weight         = unit_r;
  assign measuring_phase_weight         = measuring_phase_r;
  assign weight_mass         = mass_r;

endmodule // rscc_device
`default_nettype wire

// ==== hw/rscc_master.sv ====
`timescale 1ns/1ps
`default_nettype none
module rscc_master (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  rscc_link_if.master      link,
  input  wire logic        shared_four,
  input  wire logic        cmd_start,
  input  wire logic [15:0] cmd_number,
  input  wire logic [31:0] cmd_arg,
  input  wire logic        write_start,
  output logic             busy,
  output logic             cmd_done,
  output logic [15:0]      result_err,
  output logic [15:0]      result_aux,
  output logic             write_done
);

  logic        greq_r;
  logic        wreq_r;
  logic [15:0] cmd_r;
  logic [31:0] arg_r;
  logic        four_r;
  logic        done_r;
  logic        wdone_r;
  logic [15:0] err_r;
  logic [15:0] aux_r;

  // General command request, held until response then released
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      greq_r <= 1'b0;
      cmd_r  <= 16'h0;
      arg_r  <= 32'h0;
      four_r <= 1'b0;
      done_r <= 1'b0;
      err_r  <= 16'h0;
      aux_r  <= 16'h0;
    end
    else
    begin
      done_r <= 1'b0;
      if (!greq_r && !link.gen_resp && cmd_start && link.remote_ready && shared_four)
      begin
        greq_r <= 1'b1; // R14
        cmd_r  <= cmd_number; // R15
        arg_r  <= cmd_arg; // R15
        four_r <= shared_four;
      end
      else if (greq_r && link.gen_resp)
      begin
        greq_r <= 1'b0; // R2
        err_r  <= link.err_code; // R23
        aux_r  <= link.aux_err_code;
        done_r <= 1'b1;
      end
    end
  end

  // Setting-value write request
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      wreq_r  <= 1'b0;
      wdone_r <= 1'b0;
    end
    else
    begin
      wdone_r <= 1'b0;
      if (!wreq_r && !link.write_resp && write_start)
        wreq_r <= 1'b1;
      else if (wreq_r && link.write_resp)
      begin
        wreq_r  <= 1'b0; // R1
        wdone_r <= 1'b1;
      end
    end
  end

  assign link.gen_req        = greq_r;
  assign link.write_req      = wreq_r;
  assign link.mode_req       = 1'b0; // R4
  assign link.init_done_flag = 1'b0;
  assign link.four_station   = four_r;
  assign link.cmd_word       = cmd_r;
  assign link.arg_words      = arg_r;
  assign busy                = greq_r | link.gen_resp;
  assign cmd_done            = done_r;
  assign result_err          = err_r;
  assign result_aux          = aux_r;
  assign write_done          = wdone_r;

endmodule // rscc_master
`default_nettype wire

// ==== tb/rscc_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none
module rscc_assertions #(
  parameter int unsigned HEARTBEAT_CYCLES = rscc_pkg::HEARTBEAT_CYCLES,
  parameter int unsigned INIT_CYCLES      = rscc_pkg::INIT_CYCLES
)(
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic        write_req,
  input wire logic        write_resp,
  input wire logic        gen_req,
  input wire logic        gen_resp,
  input wire logic        rw_dir,
  input wire logic        mode_resp,
  input wire logic        cpu_alive,
  input wire logic        remote_ready,
  input wire logic [15:0] err_code,
  input wire logic [15:0] aux_err_code
);
  logic        alive_q_r;
  logic        hb_armed_r;
  logic [31:0] hb_cnt_r;
  logic [31:0] rdy_cnt_r;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  always_ff @(posedge sys_clk)
    alive_q_r <= cpu_alive;
  always_ff @(posedge sys_clk)
    if (rst || cpu_alive != alive_q_r)
      hb_cnt_r <= 32'h0;
    else if (hb_cnt_r != 32'hFFFF_FFFF)
      hb_cnt_r <= hb_cnt_r + 32'h1;
  always_ff @(posedge sys_clk)
    if (rst)
      hb_armed_r <= 1'b0;
    else if (cpu_alive != alive_q_r)
      hb_armed_r <= 1'b1;
  always_ff @(posedge sys_clk)
    if (rst)
      rdy_cnt_r <= 32'h0;
    else if (rdy_cnt_r != 32'hFFFF_FFFF)
      rdy_cnt_r <= rdy_cnt_r + 32'h1;

  write_hold_a: assert property (write_resp && write_req |=> write_resp)
    else $error("write response dropped early");
  write_clear_a: assert property (write_resp && !write_req |-> ##[1:12] !write_resp)
    else $error("write response stuck");
  cmd_hold_a: assert property (gen_resp && gen_req |=> gen_resp)
    else $error("command response dropped early");
  cmd_clear_a: assert property (gen_resp && !gen_req |-> ##[1:12] !gen_resp)
    else $error("command response stuck");
  dir_write_a: assert property (gen_resp |-> !rw_dir)
    else $error("direction not write");
  mode_low_a: assert property (!mode_resp)
    else $error("mode response raised");
  hb_rate_a: assert property (hb_armed_r && cpu_alive != alive_q_r |-> hb_cnt_r >= HEARTBEAT_CYCLES - 1)
    else $error("heartbeat too fast");
  ready_early_a: assert property (remote_ready |-> rdy_cnt_r >= INIT_CYCLES - 1)
    else $error("ready too early");
  ready_late_a: assert property (rdy_cnt_r >= INIT_CYCLES + 3 |-> remote_ready)
    else $error("ready too late");
  result_stable_a: assert property (gen_resp && $past(gen_resp) |-> $stable({err_code, aux_err_code}))
    else $error("result moved under response");
endmodule // rscc_assertions
`default_nettype wire

// ==== tb/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam logic [31:0] UNEX  = {rscc_pkg::ERR_CODE_CAL, rscc_pkg::AUX_UNEXECUTABLE};
  localparam logic [31:0] RANGE = {rscc_pkg::ERR_CODE_CAL, rscc_pkg::AUX_OUT_OF_RANGE};
  localparam logic [15:0] ENTER = rscc_pkg::CMD_ENTER_CAL;
  localparam logic [15:0] UNIT  = rscc_pkg::CMD_UNIT_WEIGHT;
  localparam logic [15:0] MEASURING_PHASE  = rscc_pkg::CMD_MEASURING_PHASE_WEIGHT;
  localparam logic [15:0] MASS  = rscc_pkg::CMD_WEIGHT_MASS;
  logic        sys_clk = 1'b0;
  logic        rst = 1'b1;
  logic        dev_write_done, store_busy, overload_positive, overflow_positive;
  logic        overload_negative, overflow_negative, weight_excess, zero_set_error;
  logic        indicator_error, measurement_display, cal_lock, cal_terminate;
  logic        cmd_start, write_start, busy, cmd_done, m_write_done, cal_mode, v, shared_four;
  logic [2:0]  dp_position, cal_step;
  logic [12:0] seq_state;
  logic [15:0] cal_bcd, cmd_number, result_err, result_aux;
  logic [31:0] cmd_arg, measuring_phase_weight, weight_mass, m_measuring_phase, w;
  logic [7:0]  unit_weight;
  logic [31:0] uw_tab [10] = '{32'h0, 32'h1, 32'h3, 32'h2, 32'h5, 32'hA, 32'h14, 32'h31, 32'h33, 32'h32};
  int          failures = 0;
  int          num_checks = 0;
  int          m_cal, m_step, n;

  always #2 sys_clk = ~sys_clk;

  rscc_link_if link ();
  rscc_device #(.HEARTBEAT_CYCLES(8), .INIT_CYCLES(4)) rscc_device_inst (
    .sys_clk(sys_clk), .rst(rst), .link(link), .write_done(dev_write_done),
    .store_busy(store_busy), .dp_position(dp_position), .seq_state(seq_state),
    .overload_positive(overload_positive), .overflow_positive(overflow_positive),
    .overload_negative(overload_negative), .overflow_negative(overflow_negative),
    .weight_excess(weight_excess), .zero_set_error(zero_set_error), .cal_number_bcd(cal_bcd),
    .indicator_error(indicator_error), .measurement_display(measurement_display),
    .cal_lock(cal_lock), .cal_terminate(cal_terminate), .cal_mode(cal_mode),
    .cal_step(cal_step), .unit_weight(unit_weight), .measuring_phase_weight(measuring_phase_weight),
    .weight_mass(weight_mass));
  rscc_master rscc_master_inst (
    .sys_clk(sys_clk), .rst(rst), .link(link), .shared_four(shared_four), .cmd_start(cmd_start),
    .cmd_number(cmd_number), .cmd_arg(cmd_arg), .write_start(write_start), .busy(busy),
    .cmd_done(cmd_done), .result_err(result_err), .result_aux(result_aux),
    .write_done(m_write_done));
  rscc_assertions #(.HEARTBEAT_CYCLES(8), .INIT_CYCLES(4)) rscc_assertions_inst (
    .sys_clk(sys_clk), .rst(rst), .write_req(link.write_req), .write_resp(link.write_resp),
    .gen_req(link.gen_req), .gen_resp(link.gen_resp), .rw_dir(link.rw_dir),
    .mode_resp(link.mode_resp), .cpu_alive(link.cpu_alive), .remote_ready(link.remote_ready),
    .err_code(link.err_code), .aux_err_code(link.aux_err_code));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic final_report();
    $display("checks=%0d failures=%0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask

  task automatic wait_for(ref logic s, input logic val);
    int i;
    i = 0;
    while (s !== val && i < 300)
    begin
      tick(1);
      i++;
    end
    if (s !== val)
    begin
      chk(32'h0, 32'h1);
      final_report();
    end
  endtask

  task automatic model(input logic [15:0] num, input logic [31:0] arg, output logic [31:0] r);
    r = 32'h0;
    case (num)
      ENTER:
        if (arg != 32'h0) r = RANGE;
        else if (!measurement_display || cal_lock || m_cal) r = UNEX;
        else {m_cal, m_step} = {32'h1, 32'h1};
      UNIT:
        if (!m_cal) r = UNEX;
        else if (!(arg inside {32'h1, 32'h2, 32'h5, 32'hA, 32'h14, 32'h32})) r = RANGE;
        else m_step = 2;
      MEASURING_PHASE:
        if (!m_cal || m_step < 2) r = UNEX;
        else if (arg < 32'h1 || arg > rscc_pkg::WEIGHT_MAX) r = RANGE;
        else {m_measuring_phase, m_step} = {arg, 32'h3};
      MASS:
        if (!m_cal || m_step < 3) r = UNEX;
        else if (arg < 32'h1 || arg > m_measuring_phase) r = RANGE;
        else m_step = 4;
      default: r = 32'h0;
    endcase
  endtask

  task automatic do_cmd(input logic [15:0] num, input logic [31:0] arg);
    logic [31:0] exp;
    logic [47:0] seen;
    seen = 48'h0;
    wait_for(busy, 1'b0);
    @(posedge sys_clk);
    cmd_number <= num;
    cmd_arg <= arg;
    cmd_start <= 1'b1;
    @(posedge sys_clk);
    cmd_start <= 1'b0;
    model(num, arg, exp);
    n = 0;
    do
    begin
      tick(1);
      n++;
      if (link.gen_resp === 1'b1)
        seen = {link.cmd_word, link.arg_words};
    end
    while (cmd_done !== 1'b1 && n < 300);
    if (cmd_done !== 1'b1)
    begin
      chk(32'h0, 32'h1);
      final_report();
    end
    chk({16'h0, seen[47:32]}, {16'h0, num});
    chk(seen[31:0], arg);
    chk({result_err, result_aux}, exp);
    wait_for(link.gen_resp, 1'b0);
  endtask

  initial
  begin
    void'($urandom(32'h4BE6));
    {dev_write_done, store_busy, seq_state, dp_position, cal_bcd, cal_lock} = '0;
    {overload_positive, overflow_positive, overload_negative, overflow_negative} = '0;
    {weight_excess, zero_set_error, indicator_error, cal_terminate, cmd_start} = '0;
    {write_start, cmd_number, cmd_arg, m_cal, m_step, m_measuring_phase} = '0;
    measurement_display = 1'b1;
    shared_four = 1'b1;
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    tick(1);
    chk(link.remote_ready, 1'b0);
    wait_for(link.remote_ready, 1'b1);
    $display("test reset done");
    repeat (8)
    begin
      @(posedge sys_clk);
      dp_position <= 3'($urandom_range(4, 0));
      seq_state <= 13'($urandom);
      {overload_positive, overflow_positive, overload_negative, overflow_negative} <= 4'($urandom & $urandom);
      {weight_excess, zero_set_error, indicator_error} <= 3'($urandom);
      cal_bcd <= {4'($urandom_range(9, 0)), 4'($urandom_range(9, 0)), 8'h87};
      tick(2);
      chk(link.dp_code, dp_position);
      chk(link.seq_status, seq_state);
      chk(link.capacity_over, overload_positive | overflow_positive | overload_negative | overflow_negative);
      chk(link.faulty_weight, weight_excess | zero_set_error);
      chk(link.cal_number_bcd, cal_bcd);
      chk(link.error_status, indicator_error);
    end
    $display("test mirror done");
    for (int t = 0; t < 2; t++)
    begin
      v = link.cpu_alive;
      n = 0;
      while (link.cpu_alive === v && n < 300)
      begin
        tick(1);
        n++;
      end
      if (link.cpu_alive === v)
      begin
        chk(32'h0, 32'h1);
        final_report();
      end
    end
    chk(n, 32'h8);
    @(posedge sys_clk);
    store_busy <= 1'b1;
    tick(3);
    v = link.cpu_alive;
    tick(24);
    chk(link.cpu_alive, v);
    @(posedge sys_clk);
    store_busy <= 1'b0;
    $display("test heartbeat done");
    @(posedge sys_clk);
    write_start <= 1'b1;
    @(posedge sys_clk);
    write_start <= 1'b0;
    wait_for(link.write_req, 1'b1);
    tick(6);
    chk(link.write_resp, 1'b0);
    @(posedge sys_clk);
    dev_write_done <= 1'b1;
    wait_for(m_write_done, 1'b1);
    @(posedge sys_clk);
    dev_write_done <= 1'b0;
    wait_for(link.write_resp, 1'b0);
    chk(link.write_req, 1'b0);
    $display("test write done");
    @(posedge sys_clk);
    shared_four <= 1'b0;
    cmd_start <= 1'b1;
    @(posedge sys_clk);
    cmd_start <= 1'b0;
    shared_four <= 1'b1;
    tick(2);
    chk(link.gen_req, 1'b0);
    do_cmd(16'h1234, 32'h0);
    do_cmd(UNIT, 32'h1);
    @(posedge sys_clk);
    measurement_display <= 1'b0;
    do_cmd(ENTER, 32'h0);
    @(posedge sys_clk);
    measurement_display <= 1'b1;
    cal_lock <= 1'b1;
    do_cmd(ENTER, 32'h0);
    @(posedge sys_clk);
    cal_lock <= 1'b0;
    do_cmd(ENTER, 32'h5);
    do_cmd(ENTER, 32'h0);
    chk(cal_mode, 1'b1);
    do_cmd(ENTER, 32'h0);
    do_cmd(MEASURING_PHASE, 32'h64);
    foreach (uw_tab[i]) do_cmd(UNIT, uw_tab[i]);
    chk(unit_weight, 32'h32);
    do_cmd(MASS, 32'h1);
    do_cmd(MEASURING_PHASE, 32'h0);
    do_cmd(MEASURING_PHASE, 32'hF4240);
    w = $urandom_range(999999, 1);
    do_cmd(MEASURING_PHASE, w);
    chk(measuring_phase_weight, w);
    do_cmd(MASS, w + 32'h1);
    do_cmd(MASS, 32'h0);
    do_cmd(MASS, w);
    chk(weight_mass, w);
    $display("test command done");
    @(posedge sys_clk);
    cal_terminate <= 1'b1;
    @(posedge sys_clk);
    cal_terminate <= 1'b0;
    tick(3);
    chk(cal_mode, 1'b0);
    chk(cal_step, rscc_pkg::CAL_STEP_NONE);
    chk(unit_weight, 32'h0);
    chk(measuring_phase_weight, 32'h0);
    chk(weight_mass, 32'h0);
    {m_cal, m_step, m_measuring_phase} = '0;
    do_cmd(MASS, 32'h1);
    @(posedge sys_clk);
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    tick(1);
    chk(link.remote_ready, 1'b0);
    wait_for(link.remote_ready, 1'b1);
    $display("test terminate done");
    final_report();
  end
endmodule // testbench
`default_nettype wire
